// ==== rtl/dia_top.sv ====
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// How it works
// (RULE1) Each source has a live status bit following its incoming event directly.
// (RULE2) Unmasked interrupt is the event ANDed with the inverted mask bit.
// (RULE3) A rising unmasked edge sets the sticky identity bit; held level does not.
// (RULE4) Writing one to an identity bit clears it; zero leaves it.
// (RULE5) Identity bit holds two events; clearing with second stored sets it again.
// (RULE6) Enabled interrupt is the identity bit ANDed with its enable bit.
// (RULE7) Enabled interrupts of a category OR into a readable pending bit.
// (RULE8) All pending bits OR into one combined display interrupt.
// (RULE9) Combined interrupt ANDed with master enable bit 31 gives enabled output.
// (RULE10) Enabled interrupt goes to the graphics interrupt processing logic.
// (RULE11) Clearing master enable drops the output at once despite pending bits.
// (RULE12) Setting master enable with pending bits raises the output again.
// (RULE13) Software clears master, reads pending, reads identity, writes ones back.
// (RULE14) Software sets master enable again only as its final step.
// (RULE15) Hotplug logic raises identity bits and holds long and short pulse status.
// (RULE16) Handler reads hotplug identity first, then that port type's pulse status.
// (RULE17) All state returns to reset values on function or chip reset.
// (RULE18) A third event while two are queued is dropped silently.
module dia_top
#(
   parameter int NSRC = dia_pkg::SOURCES_PER_CAT
)
(
   // Clock and resets
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic FLR,
   // Event sources, one vector with NSRC bits per category
   input wire logic [dia_pkg::NUM_CATEGORIES*NSRC-1:0] EVENTS,
   // Hotplug pulse detectors, one bit per port
   input wire logic [dia_pkg::HP_PORTS-1:0] HP_LONG_PULSE,
   input wire logic [dia_pkg::HP_PORTS-1:0] HP_SHORT_PULSE,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Toward graphics interrupt processing
   output logic DISPLAY_IRQ
);
   localparam int NCAT = dia_pkg::NUM_CATEGORIES;
   localparam int NALL = NCAT * NSRC;
   localparam int NHP = dia_pkg::HP_PORTS;

   dia_pkg::dia_req_s req;
   logic rst_any;
   logic [NALL-1:0] ev_sync1_reg;
   logic [NALL-1:0] ev_sync2_reg;
   logic [NHP-1:0] hl_sync1_reg;
   logic [NHP-1:0] hl_sync2_reg;
   logic [NHP-1:0] hs_sync1_reg;
   logic [NHP-1:0] hs_sync2_reg;
   logic [NALL-1:0] mask_reg;
   logic [NALL-1:0] enable_reg;
   logic [NALL-1:0] unmasked;
   logic [NALL-1:0] sticky;
   logic [NALL-1:0] second;
   logic [NALL-1:0] clear;
   logic [NALL-1:0] enabled;
   logic [NCAT-1:0] pending;
   logic combined;
   logic master_reg;
   logic [2*NHP-1:0] hp_status_reg;
   logic [7:0] grp;
   logic [7:0] idx;
   logic [31:0] rdata_next;

   assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
   assign grp = req.addr & dia_pkg::ADDR_GROUP_MASK;
   assign idx = req.addr & dia_pkg::ADDR_INDEX_MASK;

   // Function-level and chip reset both return everything to its reset value; both are async.
   assign rst_any = RST | FLR; // RULE17

   // Events come from other clock domains, so two flops before use.
   always_ff @(posedge CLOCK or posedge rst_any)
   begin
      if (rst_any)
      begin
         ev_sync1_reg <= '0;
         ev_sync2_reg <= '0;
         hl_sync1_reg <= '0;
         hl_sync2_reg <= '0;
         hs_sync1_reg <= '0;
         hs_sync2_reg <= '0;
      end
      else
      begin
         ev_sync1_reg <= EVENTS;
         ev_sync2_reg <= ev_sync1_reg;
         hl_sync1_reg <= HP_LONG_PULSE;
         hl_sync2_reg <= hl_sync1_reg;
         hs_sync1_reg <= HP_SHORT_PULSE;
         hs_sync2_reg <= hs_sync1_reg;
      end
   end

   // Mask gates each event before the edge detector.
   assign unmasked = ev_sync2_reg & ~mask_reg; // RULE2

   // One identity cell per source.
   genvar g;
   generate
      for (g = 0; g < NALL; g++)
      begin : g_ident
         assign clear[g] = req.wr && (grp == dia_pkg::ADDR_IDENT_BASE)
            && (int'(idx) == g / NSRC) && req.wdata[g % NSRC]; // RULE4
         dia_ident_bit u_bit
         (
            .clk(CLOCK),
            .rst(rst_any),
            .unmasked(unmasked[g]),
            .clear(clear[g]),
            .sticky(sticky[g]),
            .second(second[g])
         );
      end
   endgenerate

   // Enabled bits gathered per category.
   assign enabled = sticky & enable_reg; // RULE6
   generate
      for (g = 0; g < NCAT; g++)
      begin : g_cat
         assign pending[g] = |enabled[g*NSRC +: NSRC]; // RULE7
      end
   endgenerate

   // Combining is combinational so a master change acts in the same cycle.
   assign combined = |pending; // RULE8
   assign DISPLAY_IRQ = combined & master_reg; // RULE9 RULE10 RULE11 RULE12

   // Mask and enable registers, one word per category.
   always_ff @(posedge CLOCK or posedge rst_any)
   begin
      if (rst_any)
      begin
         mask_reg <= '1;
         enable_reg <= '0;
      end
      else if (req.wr && int'(idx) < NCAT)
      begin
         if (grp == dia_pkg::ADDR_MASK_BASE)
         begin
            mask_reg[int'(idx)*NSRC +: NSRC] <= req.wdata[NSRC-1:0];
         end
         if (grp == dia_pkg::ADDR_ENABLE_BASE)
         begin
            enable_reg[int'(idx)*NSRC +: NSRC] <= req.wdata[NSRC-1:0];
         end
      end
   end

   // Master enable bit of the control register.
   always_ff @(posedge CLOCK or posedge rst_any)
   begin
      if (rst_any)
      begin
         master_reg <= dia_pkg::MASTER_EN_RESET;
      end
      else if (req.wr && req.addr == dia_pkg::ADDR_CONTROL)
      begin
         master_reg <= req.wdata[dia_pkg::MASTER_EN_BIT]; // RULE11 RULE12
      end
   end

   // Hotplug pulse kind: sticky, pulses set, write one clears; set wins.
   always_ff @(posedge CLOCK or posedge rst_any)
   begin
      if (rst_any)
      begin
         hp_status_reg <= '0;
      end
      else
      begin
         for (int p = 0; p < NHP; p++)
         begin
            hp_status_reg[2*p+dia_pkg::HP_LONG_OFS] <= hl_sync2_reg[p]
               | (hp_status_reg[2*p+dia_pkg::HP_LONG_OFS]
               & ~(req.wr && req.addr == dia_pkg::ADDR_HP_STATUS
               && req.wdata[2*p+dia_pkg::HP_LONG_OFS])); // RULE15
            hp_status_reg[2*p+dia_pkg::HP_SHORT_OFS] <= hs_sync2_reg[p]
               | (hp_status_reg[2*p+dia_pkg::HP_SHORT_OFS]
               & ~(req.wr && req.addr == dia_pkg::ADDR_HP_STATUS
               && req.wdata[2*p+dia_pkg::HP_SHORT_OFS])); // RULE15
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always_comb
   begin
      rdata_next = '0;
      if (req.addr == dia_pkg::ADDR_CONTROL)
      begin
         rdata_next[NCAT-1:0] = pending; // RULE7
         rdata_next[dia_pkg::MASTER_EN_BIT] = master_reg;
      end
      else if (req.addr == dia_pkg::ADDR_HP_STATUS)
      begin
         rdata_next[2*NHP-1:0] = hp_status_reg;
      end
      else if (int'(idx) < NCAT)
      begin
         unique case (grp)
            dia_pkg::ADDR_LIVE_BASE:
               rdata_next[NSRC-1:0] = ev_sync2_reg[int'(idx)*NSRC +: NSRC]; // RULE1
            dia_pkg::ADDR_MASK_BASE:
               rdata_next[NSRC-1:0] = mask_reg[int'(idx)*NSRC +: NSRC];
            dia_pkg::ADDR_IDENT_BASE:
               rdata_next[NSRC-1:0] = sticky[int'(idx)*NSRC +: NSRC];
            dia_pkg::ADDR_ENABLE_BASE:
               rdata_next[NSRC-1:0] = enable_reg[int'(idx)*NSRC +: NSRC];
            default:
               rdata_next = '0;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge CLOCK or posedge rst_any)
   begin
      if (rst_any)
      begin
         RDATA <= '0;
      end
      else
      begin
         RDATA <= req.rd ? rdata_next : '0;
      end
   end

   // Output follows the enabled identity bits and master with no delay.
   property p_irq_formula;
      @(posedge CLOCK) disable iff (rst_any)
         DISPLAY_IRQ == ((|(sticky & enable_reg)) && master_reg);
   endproperty
   a_irq_formula: assert property (p_irq_formula) // RULE8
      else $error("Display interrupt does not match pending and master.");

   property p_master_clear_drops;
      @(posedge CLOCK) disable iff (rst_any)
         (req.wr && req.addr == dia_pkg::ADDR_CONTROL && !req.wdata[dia_pkg::MASTER_EN_BIT])
         |=> !DISPLAY_IRQ;
   endproperty
   a_master_clear_drops: assert property (p_master_clear_drops) // RULE11
      else $error("Output stayed high after master enable cleared.");

   property p_master_set_raises;
      @(posedge CLOCK) disable iff (rst_any)
         (req.wr && req.addr == dia_pkg::ADDR_CONTROL && req.wdata[dia_pkg::MASTER_EN_BIT]
         && |enabled && !(|clear)) |=> DISPLAY_IRQ;
   endproperty
   a_master_set_raises: assert property (p_master_set_raises) // RULE12
      else $error("Output not raised after master enable set with pending.");

   property p_rise_sets;
      @(posedge CLOCK) disable iff (rst_any) (unmasked[0] && !$past(unmasked[0])) |=> sticky[0];
   endproperty
   a_rise_sets: assert property (p_rise_sets) // RULE3
      else $error("Rising unmasked event did not set identity bit.");

   property p_masked_no_set;
      @(posedge CLOCK) disable iff (rst_any) (!sticky[0] && !unmasked[0]) |=> !sticky[0];
   endproperty
   a_masked_no_set: assert property (p_masked_no_set) // RULE2
      else $error("Identity bit set without an unmasked event.");

   property p_clear_single;
      @(posedge CLOCK) disable iff (rst_any)
         (clear[0] && sticky[0] && !second[0] && !unmasked[0]) |=> !sticky[0];
   endproperty
   a_clear_single: assert property (p_clear_single) // RULE4
      else $error("Write of one did not clear identity bit.");

   // A rise in the clearing cycle refills the queue, so the second slot follows it.
   sequence s_clear_queued;
      clear[0] && second[0];
   endsequence
   property p_clear_requeue;
      @(posedge CLOCK) disable iff (rst_any)
         s_clear_queued |=> sticky[0] && (second[0] == $past(g_ident[0].u_bit.rise));
   endproperty
   a_clear_requeue: assert property (p_clear_requeue) // RULE5
      else $error("Second queued event not restored after clear.");

   property p_pending_cat;
      @(posedge CLOCK) disable iff (rst_any)
         pending[dia_pkg::CAT_HOTPLUG] == |(sticky[dia_pkg::CAT_HOTPLUG*NSRC +: NSRC]
         & enable_reg[dia_pkg::CAT_HOTPLUG*NSRC +: NSRC]);
   endproperty
   a_pending_cat: assert property (p_pending_cat) // RULE7
      else $error("Hotplug pending bit wrong.");

   property p_live_read;
      @(posedge CLOCK) disable iff (rst_any)
         (req.rd && req.addr == dia_pkg::ADDR_LIVE_BASE)
         |=> RDATA == $past(ev_sync2_reg[NSRC-1:0]);
   endproperty
   a_live_read: assert property (p_live_read) // RULE1
      else $error("Live status read mismatch.");

endmodule

// ==== rtl/dia_pkg.sv ====
package dia_pkg;

   // Register index map on the plain register port.
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_LIVE_BASE = 8'h10;
   localparam logic [7:0] ADDR_MASK_BASE = 8'h20;
   localparam logic [7:0] ADDR_IDENT_BASE = 8'h30;
   localparam logic [7:0] ADDR_ENABLE_BASE = 8'h40;
   localparam logic [7:0] ADDR_HP_STATUS = 8'h50;
   localparam logic [7:0] ADDR_GROUP_MASK = 8'hF0;
   localparam logic [7:0] ADDR_INDEX_MASK = 8'h0F;

   // Control register layout.
   localparam int MASTER_EN_BIT = 31;
   localparam logic MASTER_EN_RESET = 1'b0;

   // Category numbering; hotplug is its own category.
   localparam int NUM_CATEGORIES = 5;
   localparam int CAT_PIPE = 0;
   localparam int CAT_PORT = 1;
   localparam int CAT_AUDIO = 2;
   localparam int CAT_HOTPLUG = 3;
   localparam int CAT_MISC = 4;
   localparam int SOURCES_PER_CAT = 32;

   // Hotplug pulse status layout: two bits per port, long then short.
   localparam int HP_PORTS = 8;
   localparam int HP_LONG_OFS = 0;
   localparam int HP_SHORT_OFS = 1;

   // Write and read request carried as one bundle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } dia_req_s;

endpackage

// ==== rtl/dia_ident_bit.sv ====
`timescale 1ns/1ps
// One sticky identity bit with a saturating two-deep event queue.
module dia_ident_bit
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Event side
   input wire logic unmasked,
   input wire logic clear,
   // State
   output logic sticky,
   output logic second
);
   logic prev_reg;
   logic rise;

   // Only an edge counts, so a held level does not queue again.
   assign rise = unmasked & ~prev_reg; // RULE3

   // Remember the last unmasked level.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prev_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= unmasked;
      end
   end

   // A rise in the clearing cycle is kept: set wins over clear.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sticky <= 1'b0;
         second <= 1'b0;
      end
      else if (clear && sticky)
      begin
         sticky <= second | rise; // RULE5
         second <= second & rise; // RULE4
      end
      else if (rise)
      begin
         sticky <= 1'b1; // RULE3
         second <= sticky; // RULE18
      end
   end

   // The stored second event always needs a first one in front.
   property p_second_implies_sticky;
      @(posedge clk) disable iff (rst) second |-> sticky;
   endproperty
   a_second_implies_sticky: assert property (p_second_implies_sticky) // RULE5
      else $error("Queued event without sticky bit.");

endmodule

// ==== tb/dia_irq_sink.sv ====
`timescale 1ns/1ps
// Graphics-level receiver of the display interrupt: one message per rising edge of the line.
module dia_irq_sink
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Display enabled interrupt
   input wire logic irq,
   output int count
);
   logic irq_q;

   // A held level is one message; only a fresh assertion counts as a new one.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_q <= 1'b0;
         count <= 0;
      end
      else
      begin
         irq_q <= irq;
         if (irq && !irq_q)
         begin
            count <= count + 1;
         end
      end
   end
endmodule

// ==== tb/dia_top_test.sv ====
`timescale 1ns/1ps
module dia_top_test;
   logic clock, rst, flr, wr_s, rd_s, irq;
   logic [159:0] ev;
   logic [7:0] hp_l, hp_s, addr;
   logic [31:0] wdata, rdata;
   int n_errors, n_checks, n_irq;

   dia_top dut_u (.CLOCK(clock), .RST(rst), .FLR(flr), .EVENTS(ev), .HP_LONG_PULSE(hp_l),
      .HP_SHORT_PULSE(hp_s), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .DISPLAY_IRQ(irq));
   dia_irq_sink sink_u (.clk(clock), .rst(rst), .irq(irq), .count(n_irq));

   // Free-running 10 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic summarize();
      if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clock);
      wr_s <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clock);
      rd_s <= 1'b0;
      @(negedge clock);
      chk($sformatf("register %h", a), rdata, e);
   endtask

   task automatic irq_chk(input logic e);
      @(negedge clock);
      chk("interrupt line", {31'h0, irq}, {31'h0, e});
   endtask

   // Pulses are long enough to cross the two-flop synchroniser.
   task automatic pulse(input int b);
      @(posedge clock);
      ev[b] <= 1'b1;
      cyc(4);
      ev[b] <= 1'b0;
      cyc(4);
   endtask

   task automatic t_reset();
      irq_chk(1'b0);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h20, 32'hFFFFFFFF);
      rd_chk(8'h40, 32'h0);
   endtask

   task automatic t_categories();
      for (int c = 0; c < 5; c++)
      begin
         reg_wr(8'h20 + 8'(c), 32'hFFFFFFFE);
         reg_wr(8'h40 + 8'(c), 32'h1);
         pulse(c * 32);
         rd_chk(8'h30 + 8'(c), 32'h1);
         rd_chk(8'h00, 32'h1 << c);
         irq_chk(1'b0);
         reg_wr(8'h30 + 8'(c), 32'h0);
         rd_chk(8'h30 + 8'(c), 32'h1);
         reg_wr(8'h30 + 8'(c), 32'h1);
         rd_chk(8'h30 + 8'(c), 32'h0);
      end
   endtask

   // A masked source shows live status but never reaches its identity bit.
   task automatic t_live_level();
      @(posedge clock);
      ev[33] <= 1'b1;
      ev[0] <= 1'b1;
      cyc(5);
      rd_chk(8'h11, 32'h2);
      rd_chk(8'h31, 32'h0);
      reg_wr(8'h30, 32'h1);
      cyc(4);
      rd_chk(8'h30, 32'h0);
      @(posedge clock);
      ev[33] <= 1'b0;
      ev[0] <= 1'b0;
      cyc(4);
   endtask

   task automatic t_queue();
      repeat (3) pulse(0);
      reg_wr(8'h30, 32'h1);
      rd_chk(8'h30, 32'h1);
      reg_wr(8'h30, 32'h1);
      rd_chk(8'h30, 32'h0);
   endtask

   task automatic t_master();
      pulse(0);
      reg_wr(8'h00, 32'h80000000);
      irq_chk(1'b1);
      rd_chk(8'h00, 32'h80000001);
      reg_wr(8'h00, 32'h0);
      irq_chk(1'b0);
      rd_chk(8'h00, 32'h1);
      reg_wr(8'h00, 32'h80000000);
      irq_chk(1'b1);
      cyc(1);
      irq_chk(1'b1);
      chk("message count", 32'(n_irq), 32'h2);
      reg_wr(8'h40, 32'h0);
      irq_chk(1'b0);
      reg_wr(8'h40, 32'h1);
      // Service order: disable, read pending, read and clear identity, re-enable last.
      reg_wr(8'h00, 32'h0);
      rd_chk(8'h00, 32'h1);
      rd_chk(8'h30, 32'h1);
      reg_wr(8'h30, 32'h1);
      reg_wr(8'h00, 32'h80000000);
      irq_chk(1'b0);
   endtask

   // Handler order on a hotplug event: pending bits, identity, then the pulse kind.
   task automatic t_hotplug();
      @(posedge clock);
      ev[96] <= 1'b1;
      hp_l <= 8'h01;
      hp_s <= 8'h02;
      cyc(4);
      ev[96] <= 1'b0;
      hp_l <= 8'h00;
      hp_s <= 8'h00;
      cyc(4);
      rd_chk(8'h00, 32'h80000008);
      rd_chk(8'h33, 32'h1);
      rd_chk(8'h50, 32'h9);
      reg_wr(8'h50, 32'h9);
      reg_wr(8'h33, 32'h1);
      rd_chk(8'h50, 32'h0);
      irq_chk(1'b0);
   endtask

   task automatic t_flr_unmapped();
      pulse(0);
      irq_chk(1'b1);
      @(posedge clock);
      flr <= 1'b1;
      cyc(2);
      irq_chk(1'b0);
      @(posedge clock);
      flr <= 1'b0;
      rd_chk(8'h30, 32'h0);
      rd_chk(8'h20, 32'hFFFFFFFF);
      reg_wr(8'h60, 32'hFFFFFFFF);
      rd_chk(8'h60, 32'h0);
      rd_chk(8'h35, 32'h0);
   endtask

   // Watchdog: a hang counts as a mismatch.
   initial
   begin
      #5ms;
      n_errors++;
      summarize();
   end

   initial
   begin
      rst = 1'b1;
      flr = 1'b0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      ev = '0;
      hp_l = 8'h00;
      hp_s = 8'h00;
      addr = 8'h00;
      wdata = 32'h0;
      cyc(12);
      rst <= 1'b0;
      t_reset();
      t_categories();
      t_live_level();
      t_queue();
      t_master();
      t_hotplug();
      t_flr_unmapped();
      summarize();
   end
endmodule
